// ### design/pwm_channel.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_channel
    import pwm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic pwm_tick,
    input wire logic [4:0] phase,
    input wire logic [2:0] frame_slot,
    input wire logic frame_start,
    input wire logic [7:0] data_in,
    output logic wave_out
);
    logic [7:0] active_reg;
    logic [7:0] active_next;
    logic wave_reg;
    logic wave_next;
    logic [4:0] duty;
    logic [2:0] narrow_pulse_count;
    logic insert;
    logic [5:0] high_len;

    assign active_next = frame_start ? data_in : active_reg;
    assign duty = active_reg[DUTY_MSB:DUTY_LSB];
    assign narrow_pulse_count = active_reg[NARROW_MSB:0];
    // inserted slots spread over the eight-cycle frame
    // bit0 one slot, bit1 two, bit2 three
    assign insert = (narrow_pulse_count[0] && frame_slot == 3'h3)
        || (narrow_pulse_count[1] && (frame_slot == 3'h1 || frame_slot == 3'h5))
        || (narrow_pulse_count[2]
            && (frame_slot == 3'h0 || frame_slot == 3'h2 || frame_slot == 3'h6));
    // high time equals duty, plus one clock in inserted cycles
    assign high_len = {1'b0, duty} + {5'h00, insert};
    assign wave_next = pwm_tick ? ({1'b0, phase} < high_len) : wave_reg;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            active_reg <= DATA_RESET;
            wave_reg <= 1'b0;
        end
        else
        begin
            active_reg <= active_next;
            wave_reg <= wave_next;
        end
    end

    assign wave_out = wave_reg;

    // data only changes at a frame boundary
    chk_latch_at_frame:
    assert property (@(posedge clk_sys) disable iff (reset)
        !$past(frame_start) |-> $stable(active_reg))
    else $error("active data changed mid-frame");
endmodule
`default_nettype wire

// ### design/pwm_pkg.sv
package pwm_pkg;
    localparam int CHANNELS = 5;
    localparam logic [7:0] ADDR_CTRL = 8'hA3;
    localparam logic [7:0] ADDR_CH0 = 8'hA4;
    localparam logic [7:0] ADDR_CH1 = 8'hA5;
    localparam logic [7:0] ADDR_CH2 = 8'hA6;
    localparam logic [7:0] ADDR_CH3 = 8'hA7;
    localparam logic [7:0] ADDR_CH4 = 8'hAC;
    localparam logic [7:0] ADDR_PIN_EN = 8'h9B;
    localparam int DUTY_MSB = 7;
    localparam int DUTY_LSB = 3;
    localparam int NARROW_MSB = 2;
    localparam int EN_LSB = 3;
    localparam int DIV_W = 2;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [4:0] PIN_EN_RESET = 5'h00;
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [4:0] PHASE_LAST = 5'h1F;
    localparam logic [2:0] FRAME_LAST = 3'h7;
    localparam logic [3:0] PRESCALE_ONES = 4'hF;
endpackage

// ### design/pwm_top.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_top
    import pwm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic [4:0] port1_gpio_out,
    output logic [4:0] port1_pin_out
);
    logic [7:0] data_reg [CHANNELS];
    logic [4:0] pin_en_reg;
    logic [1:0] clock_divider_field;
    logic [3:0] prescale_reg;
    logic [4:0] phase_reg;
    logic [2:0] frame_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic pwm_tick;
    logic frame_start;
    logic [3:0] div_mask;
    logic [4:0] wave;
    logic [7:0] ch_addr [CHANNELS];
    logic [CHANNELS-1:0] ch_hit;
    logic sel_ctrl;
    logic sel_en;

    assign ch_addr[0] = ADDR_CH0;
    assign ch_addr[1] = ADDR_CH1;
    assign ch_addr[2] = ADDR_CH2;
    assign ch_addr[3] = ADDR_CH3;
    assign ch_addr[4] = ADDR_CH4;
    assign sel_ctrl = (sfr_addr == ADDR_CTRL);
    assign sel_en = (sfr_addr == ADDR_PIN_EN);

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++)
        begin : g_ch
            assign ch_hit[i] = (sfr_addr == ch_addr[i]);
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                    data_reg[i] <= DATA_RESET;
                else if (sfr_wr && ch_hit[i])
                    data_reg[i] <= sfr_wdata;
            end
            pwm_channel u_ch (
                .clk_sys(clk_sys),
                .reset(reset),
                .pwm_tick(pwm_tick),
                .phase(phase_reg),
                .frame_slot(frame_reg),
                .frame_start(frame_start),
                .data_in(data_reg[i]),
                .wave_out(wave[i])
            );
            assign port1_pin_out[i] = pin_en_reg[i] ? wave[i] : port1_gpio_out[i];
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pin_en_reg <= PIN_EN_RESET;
            clock_divider_field <= DIV_RESET;
        end
        else if (sfr_wr && sel_en)
            pin_en_reg <= sfr_wdata[DUTY_MSB:EN_LSB];
        else if (sfr_wr && sel_ctrl)
            clock_divider_field <= sfr_wdata[DIV_W-1:0];
    end

    // tick when low field+1 prescaler bits are all ones
    assign div_mask = PRESCALE_ONES >> (2'h3 - clock_divider_field);
    assign pwm_tick = ((prescale_reg & div_mask) == div_mask);
    // 32 ticks per cycle, 8 cycles per frame
    assign frame_start = pwm_tick && phase_reg == PHASE_LAST && frame_reg == FRAME_LAST;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            prescale_reg <= 4'h0;
            phase_reg <= 5'h00;
            frame_reg <= 3'h0;
        end
        else
        begin
            prescale_reg <= prescale_reg + 4'h1;
            if (pwm_tick)
            begin
                phase_reg <= phase_reg + 5'h01;
                if (phase_reg == PHASE_LAST)
                    frame_reg <= frame_reg + 3'h1;
            end
        end
    end

    // readback: unused bits read zero
    always_comb
    begin
        rdata_next = 8'h00;
        for (int k = 0; k < CHANNELS; k++)
            if (ch_hit[k])
                rdata_next = data_reg[k];
        if (sel_en)
            rdata_next = {pin_en_reg, 3'h0};
        if (sel_ctrl)
            rdata_next = {6'h00, clock_divider_field};
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdata_reg <= 8'h00;
        else if (sfr_rd)
            rdata_reg <= rdata_next;
    end
    assign sfr_rdata = rdata_reg;

    chk_write_ch4:
    assert property (@(posedge clk_sys) disable iff (reset)
        sfr_wr && sfr_addr == ADDR_CH4 |=> data_reg[4] == $past(sfr_wdata))
    else $error("channel 4 write lost");

    chk_write_ch0:
    assert property (@(posedge clk_sys) disable iff (reset)
        sfr_wr && sfr_addr == ADDR_CH0 |=> data_reg[0] == $past(sfr_wdata))
    else $error("channel 0 write lost");

    chk_pin_route:
    assert property (@(posedge clk_sys) disable iff (reset)
        pin_en_reg[0] |-> port1_pin_out[0] == wave[0])
    else $error("channel 0 not routed");

    chk_tick_div16:
    assert property (@(posedge clk_sys) disable iff (reset)
        clock_divider_field == 2'h3 && pwm_tick && $stable(clock_divider_field)
        |=> (!pwm_tick || clock_divider_field != 2'h3) [*8])
    else $error("divide by 16 tick too early");

    chk_tick_div8:
    assert property (@(posedge clk_sys) disable iff (reset)
        clock_divider_field == 2'h2 && pwm_tick && $stable(clock_divider_field)
        |=> (!pwm_tick || clock_divider_field != 2'h2) [*7])
    else $error("divide by 8 tick too early");

    chk_tick_div2:
    assert property (@(posedge clk_sys) disable iff (reset)
        !$past(reset) && clock_divider_field == 2'h0 && $stable(clock_divider_field)
        |-> pwm_tick != $past(pwm_tick))
    else $error("divide by 2 tick missing");

    chk_div_write:
    assert property (@(posedge clk_sys) disable iff (reset)
        sfr_wr && sel_ctrl |=> clock_divider_field == $past(sfr_wdata[DIV_W-1:0]))
    else $error("divider field write lost");

    chk_pin_en_write:
    assert property (@(posedge clk_sys) disable iff (reset)
        sfr_wr && sel_en |=> pin_en_reg == $past(sfr_wdata[DUTY_MSB:EN_LSB]))
    else $error("pin enable write lost");

    chk_write_ch3:
    assert property (@(posedge clk_sys) disable iff (reset)
        sfr_wr && sfr_addr == ADDR_CH3 |=> data_reg[3] == $past(sfr_wdata))
    else $error("channel 3 write lost");

    chk_frame_wrap:
    assert property (@(posedge clk_sys) disable iff (reset)
        pwm_tick && phase_reg == PHASE_LAST && frame_reg == FRAME_LAST |=> frame_reg == 3'h0)
    else $error("frame did not wrap after eight cycles");

    chk_unmapped_read:
    assert property (@(posedge clk_sys) disable iff (reset)
        sfr_rd && ch_hit == '0 && !sel_en && !sel_ctrl |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");

    chk_wave_reset:
    assert property (@(posedge clk_sys) disable iff (reset)
        $past(reset) |-> wave == 5'h00)
    else $error("outputs not low after reset");

    chk_phase_wrap:
    assert property (@(posedge clk_sys) disable iff (reset)
        pwm_tick && phase_reg == PHASE_LAST |=> phase_reg == 5'h00)
    else $error("phase did not wrap at 32");

    chk_duty_low:
    assert property (@(posedge clk_sys) disable iff (reset)
        $past(reset) |-> pin_en_reg == PIN_EN_RESET && data_reg[0] == DATA_RESET)
    else $error("reset values wrong");

    chk_read_ctrl:
    assert property (@(posedge clk_sys) disable iff (reset)
        sfr_rd && sel_ctrl |=> sfr_rdata[7:2] == 6'h00)
    else $error("control upper bits not zero");
endmodule
`default_nettype wire

// ### tb/pwm_load.sv
`timescale 1ns/10ps
`default_nettype none
// stand-in for the filter on one pin: integrates high time in clocks
module pwm_load
(
    input wire logic clk_sys,
    input wire logic clr,
    input wire logic pin,
    output logic [15:0] high_count
);
    always_ff @(posedge clk_sys)
    begin
        if (clr)
            high_count <= 16'h0000;
        else if (pin)
            high_count <= high_count + 16'h0001;
    end
endmodule
`default_nettype wire

// ### tb/test_pwm_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_pwm_top
    import pwm_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic [4:0] port1_gpio_out = 5'h1E;
    logic [4:0] port1_pin_out;
    logic clr = 1'b0;
    logic [15:0] high_count;
    logic [7:0] addrs [7] = '{ADDR_CH0, ADDR_CH1, ADDR_CH2, ADDR_CH3, ADDR_CH4,
        ADDR_CTRL, ADDR_PIN_EN};
    // duty/narrow-count mix per divider code, high clocks per frame
    logic [7:0] tdata [4] = '{8'h83, 8'h84, 8'h0F, 8'h11};
    logic [15:0] texp [4] = '{16'h0106, 16'h020C, 16'h0070, 16'h0110};
    int bad_count = 0;
    int n_checks = 0;
    pwm_top i_pwm_top (
        .clk_sys(clk_sys),
        .reset(reset),
        .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata),
        .port1_gpio_out(port1_gpio_out),
        .port1_pin_out(port1_pin_out)
    );
    pwm_load i_pwm_load (
        .clk_sys(clk_sys),
        .clr(clr),
        .pin(port1_pin_out[0]),
        .high_count(high_count)
    );
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        chk({8'h00, sfr_rdata}, {8'h00, e});
    endtask
    // window length equal to one frame, so alignment does not matter
    task automatic meas(input int n, input logic [15:0] e);
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
        chk(high_count, e);
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++)
            rd(addrs[i], 8'h00);
        chk({11'h000, port1_pin_out}, 16'h001E);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
            wr(addrs[i], 8'hA1 + 8'(i));
        for (int i = 0; i < 5; i++)
            rd(addrs[i], 8'hA1 + 8'(i));
        rd(ADDR_CH4, 8'hA5);
        wr(ADDR_PIN_EN, 8'hFF);
        rd(ADDR_PIN_EN, 8'hF8);
        wr(ADDR_CTRL, 8'hFF);
        rd(ADDR_CTRL, 8'h03);
        wr(8'hA8, 8'h55);
        rd(8'hA8, 8'h00);
        $display("test registers done");
        wr(ADDR_PIN_EN, 8'h08);
        rd(ADDR_PIN_EN, 8'h08);
        chk({12'h000, port1_pin_out[4:1]}, 16'h000F);
        $display("test routing done");
        // one frame is 8 cycles of 32 pwm clocks of 2 << code system clocks
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDR_CTRL, 8'(k));
            wr(ADDR_CH0, tdata[k]);
            repeat (2 * (512 << k)) @(posedge clk_sys);
            meas(512 << k, texp[k]);
        end
        $display("test duty done");
        end_of_test();
    end
endmodule
`default_nettype wire
